// ===== rtl/vcci_regs.svh
`ifndef VCCI_REGS_SVH
`define VCCI_REGS_SVH

// Register byte offsets
`define VCCI_OFF_DATA0 8'h00
`define VCCI_OFF_DATA1 8'h04
`define VCCI_OFF_DATA2 8'h08
`define VCCI_OFF_CC0 8'h0c
`define VCCI_OFF_CC1 8'h10
`define VCCI_OFF_CCX0 8'h14
`define VCCI_OFF_CCX1 8'h18
`define VCCI_OFF_CTRL 8'h1c
`define VCCI_OFF_STAT 8'h20

// Field positions
`define VCCI_B_CRC_EN 4
`define VCCI_B_ODD_EN 5
`define VCCI_B_EVEN_EN 6
`define VCCI_B_NTSC 0
`define VCCI_B_CC_EN 1

// Reset values
`define VCCI_RST_DATA 8'h00
`define VCCI_RST_CTRL 8'h03

// Line numbers
`define VCCI_CC_LINE_ODD 10'h015
`define VCCI_CC_LINE_EVEN 10'h11c
`define VCCI_CGMS_LINE_ODD 10'h014
`define VCCI_CGMS_LINE_EVEN 10'h11b

// Timing, times in ns, counts in pclk cycles
`define VCCI_CLK_NS 50
`define VCCI_CC_BIT_NS 1986
`define VCCI_CGMS_BIT_NS 2235
`define VCCI_CC_START_NS 10500
`define VCCI_CGMS_START_NS 11200
`define VCCI_CC_BIT_CYC (`VCCI_CC_BIT_NS / `VCCI_CLK_NS)
`define VCCI_CGMS_BIT_CYC (`VCCI_CGMS_BIT_NS / `VCCI_CLK_NS)
`define VCCI_CC_START_CYC (`VCCI_CC_START_NS / `VCCI_CLK_NS)
`define VCCI_CGMS_START_CYC (`VCCI_CGMS_START_NS / `VCCI_CLK_NS)
`define VCCI_RUNIN_BITS 7
`define VCCI_BLANK_CODE 8'h10

`endif

// ===== rtl/vcci_pkg.sv
package vcci_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_WAIT = 6'b000010,
        ST_RUNIN = 6'b000100,
        ST_PRE = 6'b001000,
        ST_START = 6'b010000,
        ST_DATA = 6'b100000
    } vcci_state_e;

    typedef struct packed {
        logic line_start;
        logic field_odd;
        logic [9:0] line_num;
        logic [7:0] pix;
    } vcci_vid_s;

    typedef struct packed {
        logic active;
        logic runin;
        logic is_cgms;
        logic level;
        logic [8:0] phase;
    } vcci_wave_s;

endpackage : vcci_pkg

// ===== rtl/vcci_crc6.sv
`timescale 1ns/1ps
module vcci_crc6 (
    input wire logic [13:0] data,
    output logic [5:0] crc
);
    logic [5:0] r;
    logic fb;

    // Serial x^6+x+1 over C0 first, preset all ones
    always_comb begin
        r = 6'h3f;
        fb = 1'b0;
        for (int i = 0; i < 14; i++) begin
            fb = data[i] ^ r[5];
            r = {r[4:0], 1'b0} ^ {4'h0, fb, fb};
        end
        for (int k = 0; k < 6; k++) begin
            crc[k] = r[5-k];
        end
    end
endmodule : vcci_crc6

// ===== rtl/vcci_top.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "vcci_regs.svh"
module vcci_top import vcci_pkg::*; #(
    parameter int unsigned CC_BIT_CYC = `VCCI_CC_BIT_CYC,
    parameter int unsigned CGMS_BIT_CYC = `VCCI_CGMS_BIT_CYC,
    parameter int unsigned CC_START_CYC = `VCCI_CC_START_CYC,
    parameter int unsigned CGMS_START_CYC = `VCCI_CGMS_START_CYC,
    parameter logic [7:0] BLANK_CODE = `VCCI_BLANK_CODE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire vcci_vid_s vid,
    output vcci_wave_s wave,
    output logic [7:0] pix_out
);

    typedef struct packed {
        vcci_state_e fsm;
        logic is_cgms;
        logic [4:0] bit_cnt;
        logic [8:0] cyc_cnt;
        logic [19:0] shreg;
        logic [7:0] data0;
        logic [7:0] data1;
        logic [7:0] data2;
        logic [7:0] cc0;
        logic [7:0] cc1;
        logic [7:0] ccx0;
        logic [7:0] ccx1;
        logic [7:0] ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic ignore;
        logic [7:0] pix_out;
        vcci_wave_s wave;
    } vcci_st_s;

    localparam logic [8:0] CC_BIT = 9'(CC_BIT_CYC - 1);
    localparam logic [8:0] CGMS_BIT = 9'(CGMS_BIT_CYC - 1);
    localparam logic [8:0] CC_START = 9'(CC_START_CYC - 1);
    localparam logic [8:0] CGMS_START = 9'(CGMS_START_CYC - 1);

    vcci_st_s s_reg;
    vcci_st_s s_next;
    logic [5:0] crc;
    logic [19:0] cgms_word;
    logic cc_line;
    logic cgms_line;
    logic setup;
    logic tick;
    logic [8:0] bit_len;

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `VCCI_OFF_STAT);
    endfunction : addr_ok

    function automatic logic [7:0] par_byte(input logic [7:0] b);
        return {~^b[6:0], b[6:0]};
    endfunction : par_byte

    function automatic logic [31:0] rd_mux(input vcci_st_s st, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0;
        unique case (a)
            `VCCI_OFF_DATA0: d[7:0] = st.data0;
            `VCCI_OFF_DATA1: d[7:0] = st.data1;
            `VCCI_OFF_DATA2: d[7:0] = st.data2;
            `VCCI_OFF_CC0: d[7:0] = st.cc0;
            `VCCI_OFF_CC1: d[7:0] = st.cc1;
            `VCCI_OFF_CCX0: d[7:0] = st.ccx0;
            `VCCI_OFF_CCX1: d[7:0] = st.ccx1;
            `VCCI_OFF_CTRL: d[7:0] = st.ctrl;
            `VCCI_OFF_STAT: d[12:0] = {st.bit_cnt, st.is_cgms, st.fsm, st.ignore};
            default: d = 32'h0;
        endcase
        return d;
    endfunction : rd_mux

    vcci_crc6 u_crc (
        .data({s_reg.data1[5:0], s_reg.data2}),
        .crc(crc)
    );

    always_comb begin
        cgms_word = {s_reg.data0[3:0], s_reg.data1, s_reg.data2};
        if (s_reg.data0[`VCCI_B_CRC_EN]) begin
            cgms_word[19:14] = crc;
        end
        cc_line = s_reg.ctrl[`VCCI_B_CC_EN] &&
            ((vid.field_odd && vid.line_num == `VCCI_CC_LINE_ODD) ||
             (!vid.field_odd && vid.line_num == `VCCI_CC_LINE_EVEN));
        cgms_line = s_reg.ctrl[`VCCI_B_NTSC] &&
            ((vid.field_odd && vid.line_num == `VCCI_CGMS_LINE_ODD &&
              s_reg.data0[`VCCI_B_ODD_EN]) ||
             (!vid.field_odd && vid.line_num == `VCCI_CGMS_LINE_EVEN &&
              s_reg.data0[`VCCI_B_EVEN_EN]));
        setup = psel && !penable;
        bit_len = s_reg.is_cgms ? CGMS_BIT : CC_BIT;
        tick = (s_reg.cyc_cnt == 9'h0);
    end

    always_comb begin
        s_next = s_reg;
        // Register bus, one wait-free access phase
        s_next.pready = setup;
        s_next.pslverr = setup && !addr_ok(paddr);
        if (setup) begin
            s_next.prdata = rd_mux(s_reg, paddr);
        end
        if (psel && penable && s_reg.pready && pwrite && !s_reg.pslverr) begin
            unique case (paddr)
                `VCCI_OFF_DATA0: s_next.data0 = pwdata[7:0];
                `VCCI_OFF_DATA1: s_next.data1 = pwdata[7:0];
                `VCCI_OFF_DATA2: s_next.data2 = pwdata[7:0];
                `VCCI_OFF_CC0: s_next.cc0 = pwdata[7:0];
                `VCCI_OFF_CC1: s_next.cc1 = pwdata[7:0];
                `VCCI_OFF_CCX0: s_next.ccx0 = pwdata[7:0];
                `VCCI_OFF_CCX1: s_next.ccx1 = pwdata[7:0];
                `VCCI_OFF_CTRL: s_next.ctrl = pwdata[7:0];
                default: s_next.ctrl = s_reg.ctrl;
            endcase
        end
        // Waveform sequencer
        if (s_reg.fsm != ST_IDLE && !tick) begin
            s_next.cyc_cnt = s_reg.cyc_cnt - 9'h1;
        end
        unique case (s_reg.fsm)
            ST_IDLE: s_next.fsm = ST_IDLE;
            ST_WAIT: begin
                if (tick) begin
                    s_next.cyc_cnt = bit_len;
                    s_next.fsm = s_reg.is_cgms ? ST_PRE : ST_RUNIN;
                    s_next.bit_cnt = s_reg.is_cgms ? 5'h0 : 5'(`VCCI_RUNIN_BITS - 1);
                end
            end
            ST_RUNIN: begin
                if (tick) begin
                    s_next.cyc_cnt = bit_len;
                    s_next.bit_cnt = s_reg.bit_cnt - 5'h1;
                    if (s_reg.bit_cnt == 5'h0) begin
                        s_next.fsm = ST_PRE;
                        s_next.bit_cnt = 5'h1;
                    end
                end
            end
            ST_PRE: begin
                if (tick) begin
                    s_next.cyc_cnt = bit_len;
                    s_next.bit_cnt = s_reg.bit_cnt - 5'h1;
                    if (s_reg.bit_cnt == 5'h0) begin
                        s_next.fsm = s_reg.is_cgms ? ST_DATA : ST_START;
                        s_next.bit_cnt = 5'h13;
                    end
                end
            end
            ST_START: begin
                if (tick) begin
                    s_next.cyc_cnt = bit_len;
                    s_next.fsm = ST_DATA;
                    s_next.bit_cnt = 5'h0f;
                end
            end
            ST_DATA: begin
                if (tick) begin
                    s_next.cyc_cnt = bit_len;
                    s_next.shreg = {1'b0, s_reg.shreg[19:1]};
                    s_next.bit_cnt = s_reg.bit_cnt - 5'h1;
                    if (s_reg.bit_cnt == 5'h0) begin
                        s_next.fsm = ST_IDLE;
                    end
                end
            end
            default: s_next.fsm = ST_IDLE;
        endcase
        // Line start loads straight from the data registers
        if (vid.line_start) begin
            s_next.ignore = cc_line;
            if (cc_line) begin
                s_next.fsm = ST_WAIT;
                s_next.is_cgms = 1'b0;
                s_next.cyc_cnt = CC_START;
                s_next.bit_cnt = 5'h0;
                s_next.shreg = vid.field_odd ?
                    {4'h0, par_byte(s_reg.cc1), par_byte(s_reg.cc0)} :
                    {4'h0, par_byte(s_reg.ccx1), par_byte(s_reg.ccx0)};
            end else if (cgms_line) begin
                s_next.fsm = ST_WAIT;
                s_next.is_cgms = 1'b1;
                s_next.cyc_cnt = CGMS_START;
                s_next.bit_cnt = 5'h0;
                s_next.shreg = cgms_word;
            end else begin
                s_next.fsm = ST_IDLE;
            end
        end
        s_next.pix_out = s_next.ignore ? BLANK_CODE : vid.pix;
        s_next.wave.active = !(s_next.fsm inside {ST_IDLE, ST_WAIT});
        s_next.wave.runin = (s_next.fsm == ST_RUNIN);
        s_next.wave.is_cgms = s_next.is_cgms;
        s_next.wave.phase = s_next.cyc_cnt;
        unique case (s_next.fsm)
            ST_RUNIN: s_next.wave.level = s_next.cyc_cnt > {1'b0, bit_len[8:1]};
            ST_PRE: s_next.wave.level = s_next.is_cgms;
            ST_START: s_next.wave.level = 1'b1;
            ST_DATA: s_next.wave.level = s_next.shreg[0];
            default: s_next.wave.level = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{fsm: ST_IDLE, data0: `VCCI_RST_DATA, data1: `VCCI_RST_DATA,
                data2: `VCCI_RST_DATA, cc0: `VCCI_RST_DATA, cc1: `VCCI_RST_DATA,
                ccx0: `VCCI_RST_DATA, ccx1: `VCCI_RST_DATA, ctrl: `VCCI_RST_CTRL,
                default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign wave = s_reg.wave;
    assign pix_out = s_reg.pix_out;

    // Checks
    logic [11:0] runin_len;
    logic [11:0] runin_len_next;
    localparam logic [11:0] RUNIN_TOTAL = 12'(`VCCI_RUNIN_BITS * CC_BIT_CYC);

    always_comb begin
        runin_len_next = s_reg.wave.runin ? runin_len + 12'h1 : 12'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            runin_len <= 12'h0;
        end else begin
            runin_len <= runin_len_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cc_line_load: assert property (vid.line_start && cc_line |=>
        s_reg.fsm == ST_WAIT && !s_reg.is_cgms ##[1:300] s_reg.fsm == ST_RUNIN)
        else $error("caption line did not start run-in");
    a_runin_seven: assert property ($fell(s_reg.wave.runin) |->
        runin_len == RUNIN_TOTAL)
        else $error("run-in length wrong");
    a_start_bit_one: assert property (s_reg.fsm == ST_START |-> s_reg.wave.level)
        else $error("start bit not one");
    a_cc_parity_odd: assert property (vid.line_start && cc_line |=>
        (^s_reg.shreg[7:0]) && (^s_reg.shreg[15:8]) && s_reg.bit_cnt == 5'h0)
        else $error("caption parity not odd");
    a_ext_source: assert property (vid.line_start && cc_line && !vid.field_odd |=>
        s_reg.shreg[6:0] == $past(s_reg.ccx0[6:0]) && s_reg.shreg[14:8] == $past(s_reg.ccx1[6:0]))
        else $error("extended caption bytes not used");
    a_single_buffer: assert property (vid.line_start && cc_line && vid.field_odd |=>
        s_reg.shreg[6:0] == $past(s_reg.cc0[6:0]) && s_reg.shreg[14:8] == $past(s_reg.cc1[6:0]))
        else $error("caption bytes delayed");
    a_pixels_blank: assert property (s_reg.ignore |-> s_reg.pix_out == BLANK_CODE)
        else $error("pixel passed on caption line");
    a_cgms_gate: assert property ($rose(s_reg.is_cgms && s_reg.fsm == ST_WAIT) |->
        $past(s_reg.ctrl[`VCCI_B_NTSC]) &&
        ($past(vid.field_odd) ? $past(s_reg.data0[`VCCI_B_ODD_EN]) &&
          $past(vid.line_num) == `VCCI_CGMS_LINE_ODD :
          $past(s_reg.data0[`VCCI_B_EVEN_EN]) && $past(vid.line_num) == `VCCI_CGMS_LINE_EVEN))
        else $error("copy-management sent when not allowed");
    a_cgms_ref: assert property (s_reg.fsm == ST_PRE && s_reg.is_cgms |->
        s_reg.wave.level ##[1:300] (s_reg.fsm == ST_DATA && s_reg.bit_cnt == 5'h13))
        else $error("reference pulse or word length wrong");
    a_cgms_raw: assert property (vid.line_start && cgms_line && !cc_line &&
        !s_reg.data0[`VCCI_B_CRC_EN] |=> s_reg.shreg == $past({s_reg.data0[3:0],
        s_reg.data1, s_reg.data2}))
        else $error("raw copy-management word altered");
    a_cgms_crc: assert property (vid.line_start && cgms_line && !cc_line &&
        s_reg.data0[`VCCI_B_CRC_EN] |=> s_reg.shreg[13:0] == $past({s_reg.data1[5:0],
        s_reg.data2}) && s_reg.shreg[19:14] == $past(crc))
        else $error("crc word wrong");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("register access not answered");

    c_cc_field_even: cover property (s_reg.fsm == ST_START && !s_reg.is_cgms && !vid.field_odd);
    c_cgms_crc: cover property (s_reg.fsm == ST_DATA && s_reg.is_cgms &&
        s_reg.data0[`VCCI_B_CRC_EN]);
    c_cgms_raw: cover property (s_reg.fsm == ST_DATA && s_reg.is_cgms &&
        !s_reg.data0[`VCCI_B_CRC_EN]);
    c_apb_error: cover property (pready && pslverr);

endmodule : vcci_top

// ===== tb/vcci_rx_model.sv
`timescale 1ns/1ps
// Receiver side: slices the inserted waveform once per bit, mid period
module vcci_rx_model import vcci_pkg::*; #(
    parameter int unsigned CC_B = 4,
    parameter int unsigned CG_B = 4
) (
    input wire logic pclk,
    input wire vcci_vid_s vid,
    input wire vcci_wave_s wave,
    output logic [31:0] bits,
    output logic [5:0] nbits,
    output logic [3:0] runins,
    output logic [7:0] phase_bad
);
    int unsigned n = 0;
    int unsigned b;
    always @(posedge pclk) begin
        b = wave.is_cgms ? CG_B : CC_B;
        if (vid.line_start === 1'b1) begin
            n = 0;
            nbits <= 6'h00;
            bits <= 32'h0;
            runins <= 4'h0;
            phase_bad <= 8'h00;
        end else if (wave.active === 1'b1) begin
            if (wave.phase !== 9'(b - 1 - n % b)) begin
                phase_bad <= phase_bad + 8'h01;
            end
            if (n % b == b / 2) begin
                bits[nbits[4:0]] <= wave.level;
                nbits <= nbits + 6'h01;
                runins <= runins + {3'h0, wave.runin};
            end
            n = n + 1;
        end
    end
endmodule : vcci_rx_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "vcci_regs.svh"
module testbench import vcci_pkg::*; ;
    localparam int unsigned LINE_LEN = 140;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    vcci_vid_s vid = '0;
    vcci_wave_s wave;
    logic [7:0] pix_out;
    logic [31:0] bits;
    logic [5:0] nbits;
    logic [3:0] runins;
    logic [7:0] phase_bad;
    int errors = 0;
    int num_checks = 0;
    always #25 pclk = ~pclk;
    vcci_top #(.CC_BIT_CYC(4), .CGMS_BIT_CYC(4), .CC_START_CYC(6), .CGMS_START_CYC(6)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vid(vid), .wave(wave), .pix_out(pix_out));
    vcci_rx_model rx (
        .pclk(pclk), .vid(vid), .wave(wave), .bits(bits), .nbits(nbits), .runins(runins),
        .phase_bad(phase_bad));
    task automatic conclude;
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 8; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 8) begin
            errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask : wr
    // One video line with random pixels; pixel path compared every cycle after the first
    task automatic run_line(input logic odd, input logic [9:0] num, input logic cap);
        logic [7:0] prev;
        logic [7:0] r;
        @(posedge pclk);
        vid.line_start <= 1'b1;
        vid.field_odd <= odd;
        vid.line_num <= num;
        prev = vid.pix;
        @(posedge pclk);
        vid.line_start <= 1'b0;
        for (int i = 0; i < LINE_LEN; i++) begin
            r = 8'($urandom);
            vid.pix <= r;
            @(negedge pclk);
            if (i > 0) check("pix_out", {24'h0, cap ? `VCCI_BLANK_CODE : prev}, pix_out);
            prev = r;
            @(posedge pclk);
        end
    endtask : run_line
    function automatic logic [18:0] cc_exp(input logic [7:0] b0, input logic [7:0] b1);
        return {~^b1[6:0], b1[6:0], ~^b0[6:0], b0[6:0], 1'b1, 2'b00};
    endfunction : cc_exp
    function automatic logic [19:0] cg_exp(input logic [7:0] d0, d1, d2);
        logic [19:0] w;
        logic [5:0] r;
        logic fb;
        w = {d0[3:0], d1, d2};
        r = 6'h3f;
        if (d0[4]) begin
            for (int i = 0; i < 14; i++) begin
                fb = r[5] ^ w[i];
                r = {r[4:0], fb} ^ {4'h0, fb, 1'b0};
            end
            for (int i = 0; i < 6; i++) w[14 + i] = r[5 - i];
        end
        return w;
    endfunction : cg_exp
    initial begin
        logic [31:0] r;
        logic e;
        logic [7:0] b0, b1, d0, d1, d2;
        logic odd, pal, sent;
        void'($urandom(32'hd1e4));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `VCCI_OFF_CTRL, 32'h0, r, e);
        check("ctrl reset", {24'h0, `VCCI_RST_CTRL}, r);
        apb(1'b0, `VCCI_OFF_DATA0, 32'h0, r, e);
        check("data0 reset", 32'h0, r);
        apb(1'b0, 8'h24, 32'h0, r, e);
        check("unmapped err", 32'h1, {31'h0, e});
        apb(1'b0, 8'h02, 32'h0, r, e);
        check("misaligned err", 32'h1, {31'h0, e});
        for (int i = 0; i < 8; i++) begin
            odd = i[0];
            b0 = (i < 2) ? 8'h00 : 8'($urandom);
            b1 = (i < 2) ? 8'h00 : 8'($urandom);
            wr(odd ? `VCCI_OFF_CCX0 : `VCCI_OFF_CC0, ~b0);
            wr(odd ? `VCCI_OFF_CC0 : `VCCI_OFF_CCX0, b0);
            wr(odd ? `VCCI_OFF_CC1 : `VCCI_OFF_CCX1, b1);
            run_line(odd, odd ? 10'd21 : 10'd284, 1'b1);
            check("cc runin", 32'd7, {28'h0, runins});
            check("cc bits", {13'h0, cc_exp(b0, b1)}, {13'h0, bits[25:7]});
            check("cc phase", 32'h0, {24'h0, phase_bad});
        end
        for (int i = 0; i < 12; i++) begin
            odd = i[0];
            pal = (i % 5 == 4);
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            d2 = 8'($urandom);
            wr(`VCCI_OFF_CTRL, {6'h0, 1'b1, ~pal});
            wr(`VCCI_OFF_DATA0, d0);
            wr(`VCCI_OFF_DATA1, d1);
            wr(`VCCI_OFF_DATA2, d2);
            run_line(odd, odd ? 10'd20 : 10'd283, 1'b0);
            sent = ~pal & (odd ? d0[5] : d0[6]);
            check("cgms count", sent ? 32'd21 : 32'd0, {26'h0, nbits});
            if (sent) check("cgms word", {11'h0, cg_exp(d0, d1, d2), 1'b1}, {11'h0, bits[20:0]});
            if (sent) check("cgms phase", 32'h0, {24'h0, phase_bad});
            run_line(~odd, odd ? 10'd20 : 10'd283, 1'b0);
            check("cgms wrong field", 32'd0, {26'h0, nbits});
        end
        wr(`VCCI_OFF_CTRL, 8'h01);
        run_line(1'b1, 10'd21, 1'b0);
        check("cc disabled", 32'd0, {26'h0, nbits});
        conclude();
    end
endmodule : testbench
